// ### hw/fpr_cfg.svh
/*
 * Constants of the flash range protection block: register offsets, field
 * positions, reset values, address bounds of the protected ranges.
 * Assumes it is included by bare name from the design and bench modules.
 */
`ifndef FPR_CFG_SVH
`define FPR_CFG_SVH

// register byte offsets on the bus
`define FPR_OFF_CFG 8'h00
`define FPR_OFF_STS 8'h04
`define FPR_OFF_IEN 8'h08
`define FPR_OFF_ICLR 8'h0c
`define FPR_OFF_CMD 8'h10
`define FPR_OFF_W 8

// protection byte fields
`define FPR_POL_BIT 7
`define FPR_SPARE_BIT 6
`define FPR_HDIS_BIT 5
`define FPR_HS_HI 4
`define FPR_HS_LO 3
`define FPR_LDIS_BIT 2
`define FPR_LS_HI 1
`define FPR_LS_LO 0
`define FPR_CFG_RST 8'hff

// command register fields
`define FPR_CMD_ADDR_HI 15
`define FPR_CMD_ERASE_BIT 16
`define FPR_CMD_MASS_BIT 17

// status / interrupt bits
`define FPR_EV_W 2
`define FPR_EV_VIOL 0
`define FPR_EV_LAUNCH 1

// reset-time fetch address of the protection byte
`define FPR_NVM_PROT_ADDR 16'hff0d

// high range starts, all ending at the top of the map
`define FPR_HI_END 16'hffff
`define FPR_HI_START0 16'hf800
`define FPR_HI_START1 16'hf000
`define FPR_HI_START2 16'he000
`define FPR_HI_START3 16'hc000

// low range ends, all starting at the same base
`define FPR_LO_START 16'h4000
`define FPR_LO_END0 16'h41ff
`define FPR_LO_END1 16'h43ff
`define FPR_LO_END2 16'h47ff
`define FPR_LO_END3 16'h4fff

`endif

// ### hw/fpr_pkg.sv
/*
 * Types shared by the flash range protection block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpr_pkg;
	// load sequence: fetch the protection byte, then normal operation
	typedef enum logic [0:0] {
		FPR_ST_LOAD,
		FPR_ST_RUN
	} fpr_state_t;
endpackage

// ### hw/fpr_range_dec.sv
/*
 * One protection range decoder: tells whether a 16-bit address falls in
 * the enabled high or low range selected by the two-bit size field.
 * Assumes the caller owns polarity; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fpr_cfg.svh"

module fpr_range_dec #(
	parameter bit IS_HIGH = 1'b0
) (
	input wire logic [15:0] addr_i, // address under test
	input wire logic [1:0] size_i, // range size select
	input wire logic dis_i, // range disable, 1 = no range
	output logic hit_o // address inside the enabled range
);
	logic [15:0] lo_bound;
	logic [15:0] hi_bound;

	// bounds per size; the high range is top-anchored, the low one base-anchored
	always_comb begin
		if (IS_HIGH) begin
			hi_bound = `FPR_HI_END;
			unique case (size_i)
				2'h0: lo_bound = `FPR_HI_START0;
				2'h1: lo_bound = `FPR_HI_START1;
				2'h2: lo_bound = `FPR_HI_START2;
				2'h3: lo_bound = `FPR_HI_START3;
			endcase
		end else begin
			lo_bound = `FPR_LO_START;
			unique case (size_i)
				2'h0: hi_bound = `FPR_LO_END0;
				2'h1: hi_bound = `FPR_LO_END1;
				2'h2: hi_bound = `FPR_LO_END2;
				2'h3: hi_bound = `FPR_LO_END3;
			endcase
		end
		hit_o = !dis_i && (addr_i >= lo_bound) && (addr_i <= hi_bound);
	end
endmodule
`default_nettype wire

// ### hw/fpr_event_irq.sv
/*
 * Sticky event status, interrupt enable and write-one-to-clear logic with
 * one level interrupt. Assumes set and write strobes are one-cycle pulses.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fpr_cfg.svh"

module fpr_event_irq (
	input wire logic ref_clk_i, // block clock
	input wire logic reset_n_i, // synchronous reset, active low
	input wire logic [`FPR_EV_W-1:0] set_i, // event pulses
	input wire logic en_we_i, // enable register write strobe
	input wire logic clr_we_i, // clear register write strobe
	input wire logic [`FPR_EV_W-1:0] wdata_i, // write data
	output logic [`FPR_EV_W-1:0] sts_o, // sticky status
	output logic [`FPR_EV_W-1:0] en_o, // interrupt enables
	output logic irq_o // level interrupt, registered
);
	logic [`FPR_EV_W-1:0] sts_r, sts_nxt, en_r, en_nxt;
	logic irq_r, irq_nxt;

	// set wins over a clear in the same cycle so no event is lost
	always_comb begin
		en_nxt = en_we_i ? wdata_i : en_r;
		sts_nxt = (sts_r & ~(clr_we_i ? wdata_i : '0)) | set_i;
		irq_nxt = |(sts_nxt & en_nxt);
	end

	// registers only
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			sts_r <= '0;
			en_r <= '0;
			irq_r <= 1'b0;
		end else begin
			sts_r <= sts_nxt;
			en_r <= en_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign sts_o = sts_r;
	assign en_o = en_r;
	assign irq_o = irq_r;

	a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		irq_r == |(sts_r & en_r))
		else $error("interrupt level does not match enabled status");
endmodule
`default_nettype wire

// ### hw/fpr_flash_range_protection.sv
/*
 * Flash range protection: holds the protection byte, loads it from flash
 * at reset, gates software writes field by field, and checks program and
 * erase commands against the protected ranges. AHB-Lite register slave.
 * Assumes one 10 MHz clock, synchronous inputs, word-only bus transfers,
 * and a flash reader that answers the reset-time fetch with a valid pulse.
 */
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fpr_cfg.svh"

module fpr_flash_range_protection (
	input wire logic ref_clk_i, // 10 MHz block clock
	input wire logic reset_n_i, // synchronous reset, active low
	input wire logic hsel_i, // AHB slave select
	input wire logic [31:0] haddr_i, // AHB address
	input wire logic [1:0] htrans_i, // AHB transfer type
	input wire logic hwrite_i, // AHB write
	input wire logic [2:0] hsize_i, // AHB size, word only
	input wire logic [31:0] hwdata_i, // AHB write data
	input wire logic hready_i, // AHB bus ready
	output logic hreadyout_o, // AHB slave ready
	output logic hresp_o, // AHB response, always okay
	output logic [31:0] hrdata_o, // AHB read data
	output logic nvm_rd_o, // fetch request of the protection byte
	output logic [15:0] nvm_addr_o, // flash address of the fetch
	input wire logic [7:0] nvm_rdata_i, // fetched byte
	input wire logic nvm_rvalid_i, // fetched byte valid
	output logic cmd_launch_o, // pulse: accepted command to the controller
	output logic [15:0] cmd_addr_o, // target address of the command
	output logic cmd_erase_o, // 1 erase, 0 program
	output logic cmd_mass_o, // mass erase
	output logic [7:0] prot_config_o, // current protection byte
	output logic irq_o // level interrupt
);
	fpr_pkg::fpr_state_t state_r, state_nxt;
	logic [7:0] cfg_r, cfg_nxt;
	logic nvm_rd_r, nvm_rd_nxt;
	logic dp_we_r, dp_we_nxt;
	logic [`FPR_OFF_W-1:0] dp_addr_r, dp_addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic launch_r, launch_nxt, erase_r, erase_nxt, mass_r, mass_nxt;
	logic [15:0] caddr_r, caddr_nxt;
	logic [`FPR_EV_W-1:0] sts, ien, ev_set;
	logic ap_sel, cfg_we, cmd_go, ien_we, iclr_we;
	logic high_hit, low_hit, range_hit, prot_hit, fully_open, refuse;
	logic [7:0] wv;

	// address phase is taken when the bus is ready and a transfer is valid
	assign ap_sel = hsel_i && hready_i && htrans_i[1];
	assign wv = hwdata_i[7:0];
	assign cfg_we = dp_we_r && (dp_addr_r == `FPR_OFF_CFG) && (state_r == fpr_pkg::FPR_ST_RUN);
	assign ien_we = dp_we_r && (dp_addr_r == `FPR_OFF_IEN);
	assign iclr_we = dp_we_r && (dp_addr_r == `FPR_OFF_ICLR);
	assign cmd_go = dp_we_r && (dp_addr_r == `FPR_OFF_CMD) && (state_r == fpr_pkg::FPR_ST_RUN);

	// range decoders look at the address written with the command
	fpr_range_dec #(.IS_HIGH(1'b1)) u_high (
		.addr_i(hwdata_i[`FPR_CMD_ADDR_HI:0]),
		.size_i(cfg_r[`FPR_HS_HI:`FPR_HS_LO]),
		.dis_i(cfg_r[`FPR_HDIS_BIT]),
		.hit_o(high_hit)
	);
	fpr_range_dec #(.IS_HIGH(1'b0)) u_low (
		.addr_i(hwdata_i[`FPR_CMD_ADDR_HI:0]),
		.size_i(cfg_r[`FPR_LS_HI:`FPR_LS_LO]),
		.dis_i(cfg_r[`FPR_LDIS_BIT]),
		.hit_o(low_hit)
	);

	// polarity swaps whether a range hit means protected or open;
	// with polarity zero and no enabled range nothing is open at all
	always_comb begin
		range_hit = high_hit || low_hit;
		prot_hit = cfg_r[`FPR_POL_BIT] ? range_hit : !range_hit;
		fully_open = cfg_r[`FPR_POL_BIT] && cfg_r[`FPR_HDIS_BIT] && cfg_r[`FPR_LDIS_BIT];
		// an open violation flag also blocks any new launch
		refuse = (hwdata_i[`FPR_CMD_MASS_BIT] ? !fully_open : prot_hit) || sts[`FPR_EV_VIOL];
		ev_set = '0;
		ev_set[`FPR_EV_VIOL] = cmd_go && refuse;
		ev_set[`FPR_EV_LAUNCH] = cmd_go && !refuse;
	end

	// load sequence and protection byte next values
	always_comb begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		nvm_rd_nxt = 1'b0;
		unique case (state_r)
			fpr_pkg::FPR_ST_LOAD: begin
				nvm_rd_nxt = !nvm_rvalid_i;
				if (nvm_rvalid_i) begin
					cfg_nxt = nvm_rdata_i;
					state_nxt = fpr_pkg::FPR_ST_RUN;
				end
			end
			fpr_pkg::FPR_ST_RUN: begin
				if (cfg_we) begin
					// polarity only ever goes from one to zero
					cfg_nxt[`FPR_POL_BIT] = cfg_r[`FPR_POL_BIT] && wv[`FPR_POL_BIT];
					cfg_nxt[`FPR_HDIS_BIT] = wv[`FPR_HDIS_BIT];
					cfg_nxt[`FPR_LDIS_BIT] = wv[`FPR_LDIS_BIT];
					// sizes are frozen once their range is enabled
					if (cfg_r[`FPR_HDIS_BIT]) begin
						cfg_nxt[`FPR_HS_HI:`FPR_HS_LO] = wv[`FPR_HS_HI:`FPR_HS_LO];
					end
					if (cfg_r[`FPR_LDIS_BIT]) begin
						cfg_nxt[`FPR_LS_HI:`FPR_LS_LO] = wv[`FPR_LS_HI:`FPR_LS_LO];
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			state_r <= fpr_pkg::FPR_ST_LOAD;
			cfg_r <= `FPR_CFG_RST;
			nvm_rd_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			nvm_rd_r <= nvm_rd_nxt;
		end
	end

	// bus slave: zero wait states; read data is latched at the address phase,
	// so a read right behind a write to the same register sees the old value
	always_comb begin
		dp_we_nxt = ap_sel && hwrite_i;
		dp_addr_nxt = ap_sel ? haddr_i[`FPR_OFF_W-1:0] : dp_addr_r;
		hrdata_nxt = hrdata_r;
		if (ap_sel && !hwrite_i) begin
			unique case (haddr_i[`FPR_OFF_W-1:0])
				`FPR_OFF_CFG: hrdata_nxt = {24'h0, cfg_r};
				`FPR_OFF_STS: hrdata_nxt = {30'h0, sts};
				`FPR_OFF_IEN: hrdata_nxt = {30'h0, ien};
				`FPR_OFF_CMD: hrdata_nxt = {14'h0, mass_r, erase_r, caddr_r};
				default: hrdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			dp_we_r <= 1'b0;
			dp_addr_r <= '0;
			hrdata_r <= 32'h0;
		end else begin
			dp_we_r <= dp_we_nxt;
			dp_addr_r <= dp_addr_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	// command hand-off: only commands that pass the check raise the launch; address and type follow every command write
	always_comb begin
		launch_nxt = cmd_go && !refuse;
		caddr_nxt = caddr_r;
		erase_nxt = erase_r;
		mass_nxt = mass_r;
		if (cmd_go) begin
			caddr_nxt = hwdata_i[`FPR_CMD_ADDR_HI:0];
			erase_nxt = hwdata_i[`FPR_CMD_ERASE_BIT];
			mass_nxt = hwdata_i[`FPR_CMD_MASS_BIT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			launch_r <= 1'b0;
			caddr_r <= 16'h0;
			erase_r <= 1'b0;
			mass_r <= 1'b0;
		end else begin
			launch_r <= launch_nxt;
			caddr_r <= caddr_nxt;
			erase_r <= erase_nxt;
			mass_r <= mass_nxt;
		end
	end

	fpr_event_irq u_evt (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.set_i(ev_set),
		.en_we_i(ien_we),
		.clr_we_i(iclr_we),
		.wdata_i(hwdata_i[`FPR_EV_W-1:0]),
		.sts_o(sts),
		.en_o(ien),
		.irq_o(irq_o)
	);

	// outputs straight from flops or tied to constants
	assign hreadyout_o = 1'b1; // zero wait states, ready never drops
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_r;
	assign nvm_rd_o = nvm_rd_r;
	assign nvm_addr_o = `FPR_NVM_PROT_ADDR;
	assign cmd_launch_o = launch_r;
	assign cmd_addr_o = caddr_r;
	assign cmd_erase_o = erase_r;
	assign cmd_mass_o = mass_r;
	assign prot_config_o = cfg_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_pol_never_set: assert property (
		state_r == fpr_pkg::FPR_ST_RUN |=> !$rose(cfg_r[`FPR_POL_BIT]))
		else $error("polarity bit went from zero to one");
	a_hsize_frozen: assert property (
		state_r == fpr_pkg::FPR_ST_RUN && !cfg_r[`FPR_HDIS_BIT]
		|=> $stable(cfg_r[`FPR_HS_HI:`FPR_HS_LO]))
		else $error("high size changed while high range enabled");
	a_lsize_frozen: assert property (
		state_r == fpr_pkg::FPR_ST_RUN && !cfg_r[`FPR_LDIS_BIT]
		|=> $stable(cfg_r[`FPR_LS_HI:`FPR_LS_LO]))
		else $error("low size changed while low range enabled");
	a_full_protect: assert property (
		!cfg_r[`FPR_POL_BIT] && cfg_r[`FPR_HDIS_BIT] && cfg_r[`FPR_LDIS_BIT] |-> prot_hit)
		else $error("address open although whole array protected");
	a_no_protect: assert property (
		fully_open |-> !prot_hit)
		else $error("address protected although protection off");
	a_high_top: assert property (
		cfg_r[`FPR_POL_BIT] && !cfg_r[`FPR_HDIS_BIT] && hwdata_i[15:0] == `FPR_HI_END |-> prot_hit)
		else $error("top address not inside enabled high range");
	a_low_base: assert property (
		!cfg_r[`FPR_POL_BIT] && !cfg_r[`FPR_LDIS_BIT] && hwdata_i[15:0] == `FPR_LO_START
		|-> !prot_hit)
		else $error("low range base not open");
	a_viol_flag: assert property (
		cmd_go && refuse |=> sts[`FPR_EV_VIOL] && !cmd_launch_o)
		else $error("refused command launched or not flagged");
	a_launch_ok: assert property (
		cmd_go && !refuse |=> cmd_launch_o)
		else $error("accepted command not launched");
	a_launch_pulse: assert property (
		!cmd_go |=> !cmd_launch_o)
		else $error("launch pulse without a command write");
	// a refused mass erase must never reach the controller
	a_mass_refuse: assert property (
		cmd_go && hwdata_i[`FPR_CMD_MASS_BIT] && !fully_open |=> !cmd_launch_o)
		else $error("mass erase launched while protection active");
	a_load_byte: assert property (
		state_r == fpr_pkg::FPR_ST_LOAD && nvm_rvalid_i
		|=> cfg_r == $past(nvm_rdata_i) && state_r == fpr_pkg::FPR_ST_RUN)
		else $error("protection byte not loaded from flash");
	a_cfg_write: assert property (
		cfg_we |=> cfg_r[`FPR_HDIS_BIT] == $past(wv[`FPR_HDIS_BIT]))
		else $error("software write to protection byte lost");
	// size fields follow the write while their range is still disabled
	a_hsize_write: assert property (
		cfg_we && cfg_r[`FPR_HDIS_BIT]
		|=> cfg_r[`FPR_HS_HI:`FPR_HS_LO] == $past(wv[`FPR_HS_HI:`FPR_HS_LO]))
		else $error("high size write lost while high range disabled");
	a_lsize_write: assert property (
		cfg_we && cfg_r[`FPR_LDIS_BIT]
		|=> cfg_r[`FPR_LS_HI:`FPR_LS_LO] == $past(wv[`FPR_LS_HI:`FPR_LS_LO]))
		else $error("low size write lost while low range disabled");
	// below the low base no range can hit, so polarity one leaves it open
	a_base_open: assert property (
		cfg_r[`FPR_POL_BIT] && hwdata_i[15:0] < `FPR_LO_START |-> !prot_hit)
		else $error("address below both ranges protected");
	// the spare flag keeps its loaded value, software cannot touch it
	a_spare_kept: assert property (
		state_r == fpr_pkg::FPR_ST_RUN |=> $stable(cfg_r[`FPR_SPARE_BIT]))
		else $error("spare flag bit changed after load");
	// while the byte is being fetched nothing else may change it
	a_load_gate: assert property (
		state_r == fpr_pkg::FPR_ST_LOAD && !nvm_rvalid_i |=> $stable(cfg_r))
		else $error("protection byte changed before fetch completed");
	a_fetch_done: assert property (
		state_r == fpr_pkg::FPR_ST_RUN |-> !nvm_rd_o)
		else $error("fetch request still up after load");
	// command outputs hold between command writes
	a_cmd_hold: assert property (
		!cmd_go |=> $stable({cmd_mass_o, cmd_erase_o, cmd_addr_o}))
		else $error("command outputs changed without a command write");

	c_load: cover property (state_r == fpr_pkg::FPR_ST_LOAD ##1 state_r == fpr_pkg::FPR_ST_RUN);
	c_refused: cover property (cmd_go && refuse);
	c_launched: cover property (cmd_launch_o && cmd_erase_o);
	c_pol_clear: cover property ($fell(cfg_r[`FPR_POL_BIT]));
	c_mass_ok: cover property (cmd_launch_o && cmd_mass_o);
endmodule
`default_nettype wire

// ### tb/fpr_flash_range_protection_test.sv
/*
 * Self-checking bench of the flash range protection block: loads the byte
 * at reset, walks polarity, disable and size settings, launches commands.
 * Assumes the design files under hw/ and a single 10 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "fpr_cfg.svh"

module fpr_flash_range_protection_test;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout_o, hresp_o, nvm_rd_o, nvm_rvalid = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_o;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [15:0] nvm_addr_o, cmd_addr_o;
	logic [7:0] nvm_rdata = 8'h00, prot_config_o;
	logic cmd_launch_o, cmd_erase_o, cmd_mass_o, irq_o;
	int fail_count = 0, check_count = 0, launch_cnt = 0;
	logic [15:0] hs_t[4] = '{16'hf800, 16'hf000, 16'he000, 16'hc000};
	logic [15:0] le_t[4] = '{16'h41ff, 16'h43ff, 16'h47ff, 16'h4fff};
	logic [31:0] r;

	// single slave, so its ready is the bus ready
	assign hready = hreadyout_o;

	fpr_flash_range_protection fpr_flash_range_protection_i (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
		.nvm_rd_o(nvm_rd_o), .nvm_addr_o(nvm_addr_o), .nvm_rdata_i(nvm_rdata),
		.nvm_rvalid_i(nvm_rvalid), .cmd_launch_o(cmd_launch_o), .cmd_addr_o(cmd_addr_o),
		.cmd_erase_o(cmd_erase_o), .cmd_mass_o(cmd_mass_o), .prot_config_o(prot_config_o),
		.irq_o(irq_o)
	);

	// 100 ns period
	always #50 ref_clk_i = ~ref_clk_i;

	// count accepted launches, a pulse is seen once per edge
	always @(posedge ref_clk_i) begin
		if (cmd_launch_o === 1'b1) launch_cnt++;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one single word transfer; entered just after a rising edge; waits on ready
	// as long as it takes, only the watchdog ends a stuck transfer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do begin
			@(posedge ref_clk_i);
		end while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin
			@(posedge ref_clk_i);
		end while (hready !== 1'b1);
		rd = hrdata_o;
	endtask

	task automatic cfg_chk(input logic [7:0] e);
		logic [31:0] rd;
		bus(1'b0, `FPR_OFF_CFG, 32'h0, rd);
		chk("cfg", {24'h0, e}, rd);
		chk("prot_config", {24'h0, e}, {24'h0, prot_config_o});
	endtask

	// launch one command, expect either a launch or a violation, then clear
	task automatic cmd_try(input logic [15:0] a, input logic ms, input logic v);
		int c0;
		logic [31:0] rd;
		c0 = launch_cnt;
		bus(1'b1, `FPR_OFF_CMD, {14'h0, ms, 1'b1, a}, rd);
		bus(1'b0, `FPR_OFF_STS, 32'h0, rd);
		chk("sts", {30'h0, !v, v}, rd);
		chk("launches", v ? 32'h0 : 32'h1, 32'(launch_cnt - c0));
		chk("cmd", {14'h0, ms, 1'b1, a}, {14'h0, cmd_mass_o, cmd_erase_o, cmd_addr_o});
		bus(1'b1, `FPR_OFF_ICLR, 32'h3, rd);
	endtask

	// expected protection worked out from polarity, disables and sizes
	function automatic logic prot(input logic pv, input logic hd, input logic ld,
		input logic [1:0] s, input logic [15:0] a);
		logic hh, lh;
		hh = !hd && a >= hs_t[s];
		lh = !ld && a >= 16'h4000 && a <= le_t[s];
		return pv ? (hh | lh) : !(hh | lh);
	endfunction

	// watchdog sized well above the expected 1300 or so cycles
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		fail_count++;
		test_done;
	end

	initial begin
		logic pv, hd, ld;
		logic [1:0] ss;
		logic [7:0] v1;
		logic [15:0] hb, lb;
		int n;
		repeat (2) @(posedge ref_clk_i);
		chk("prot_config reset", 32'hff, {24'h0, prot_config_o});
		reset_n_i <= 1'b1;
		n = 0;
		do begin @(posedge ref_clk_i); n++; end while (nvm_rd_o !== 1'b1 && n < 20);
		chk("fetch req", 32'h1, {31'h0, nvm_rd_o});
		chk("fetch addr", 32'h0000ff0d, {16'h0, nvm_addr_o});
		// stored byte: spare flag left erased, both ranges enabled at full size
		nvm_rdata <= 8'hdb;
		nvm_rvalid <= 1'b1;
		@(posedge ref_clk_i);
		nvm_rvalid <= 1'b0;
		@(posedge ref_clk_i);
		chk("fetch done", 32'h0, {31'h0, nvm_rd_o});
		cfg_chk(8'hdb);
		chk("hresp", 32'h0, {31'h0, hresp_o});
		$display("test reset load done");

		// loaded ranges: high 16K and low 4K both protected
		cmd_try(16'hc000, 1'b0, 1'b1);
		cmd_try(16'h4fff, 1'b0, 1'b1);
		cmd_try(16'h5000, 1'b0, 1'b0);
		cmd_try(16'h0000, 1'b1, 1'b1);
		// sizes are gated by the old disable value; software keeps the spare bit set
		bus(1'b1, `FPR_OFF_CFG, 32'hc0, r);
		cfg_chk(8'hdb);
		bus(1'b1, `FPR_OFF_CFG, 32'he4, r);
		cfg_chk(8'hff);
		bus(1'b1, `FPR_OFF_CFG, 32'he4, r);
		cfg_chk(8'he4);
		$display("test field gating done");

		// every polarity, disable and shared size combination
		for (int p = 1; p >= 0; p--) begin
			for (int s = 0; s < 4; s++) begin
				for (int d = 0; d < 4; d++) begin
					pv = p[0];
					ss = s[1:0];
					hd = d[1];
					ld = d[0];
					hb = hs_t[ss];
					lb = le_t[ss];
					v1 = {pv, 1'b1, 1'b1, ss, 1'b1, ss};
					bus(1'b1, `FPR_OFF_CFG, {24'h0, v1}, r);
					bus(1'b1, `FPR_OFF_CFG, {24'h0, v1}, r);
					bus(1'b1, `FPR_OFF_CFG, {24'h0, pv, 1'b1, hd, ss, ld, ss}, r);
					cfg_chk({pv, 1'b1, hd, ss, ld, ss});
					cmd_try(hb - 16'h1, 1'b0, prot(pv, hd, ld, ss, hb - 16'h1));
					cmd_try(hb, 1'b0, prot(pv, hd, ld, ss, hb));
					cmd_try(lb, 1'b0, prot(pv, hd, ld, ss, lb));
					cmd_try(lb + 16'h1, 1'b0, prot(pv, hd, ld, ss, lb + 16'h1));
					cmd_try(16'h0000, 1'b1, !(pv && hd && ld));
				end
			end
		end
		$display("test range matrix done");

		// polarity cannot be set again once cleared; both ranges off, sizes to zero
		bus(1'b1, `FPR_OFF_CFG, 32'he4, r);
		bus(1'b1, `FPR_OFF_CFG, 32'he4, r);
		cfg_chk(8'h64);
		cmd_try(16'h8000, 1'b0, 1'b1);
		$display("test polarity done");

		// interrupt raised, masked, cleared; unmapped place reads zero
		bus(1'b1, `FPR_OFF_IEN, 32'h1, r);
		bus(1'b1, `FPR_OFF_CMD, 32'h00018000, r);
		repeat (3) @(posedge ref_clk_i);
		chk("irq on", 32'h1, {31'h0, irq_o});
		bus(1'b1, `FPR_OFF_IEN, 32'h0, r);
		repeat (2) @(posedge ref_clk_i);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		bus(1'b1, `FPR_OFF_IEN, 32'h1, r);
		repeat (2) @(posedge ref_clk_i);
		chk("irq again", 32'h1, {31'h0, irq_o});
		bus(1'b1, `FPR_OFF_ICLR, 32'h3, r);
		repeat (2) @(posedge ref_clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		bus(1'b0, `FPR_OFF_STS, 32'h0, r);
		chk("sts cleared", 32'h0, r);
		bus(1'b1, 8'h20, 32'hffffffff, r);
		bus(1'b0, 8'h20, 32'h0, r);
		chk("unmapped", 32'h0, r);
		$display("test interrupt done");
		test_done;
	end
endmodule
`default_nettype wire
